// [core/scp_ctl_stream.sv]
// control bit memory and control output stream serialiser
`timescale 1ns/10ps
`default_nettype none
module scp_ctl_stream (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [scp_pkg::RATE_W-1:0] rate,
    input wire logic bit_en,
    input wire logic frame_start,
    input wire logic wr_en,
    input wire logic [scp_pkg::CM_AW-1:0] word_addr,
    input wire logic [scp_pkg::DATA_W-1:0] wr_data,
    output var logic [scp_pkg::DATA_W-1:0] rd_data,
    output var logic bit_out
);
    import scp_pkg::*;

    logic [DATA_W-1:0] cm_mem [0:CM_WORDS-1];
    logic [CM_BIT_W-1:0] bit_idx_r;
    logic [11:0] frame_bits;
    logic [CM_BIT_W-1:0] last_bit;

    // ========================================================
    // frame length follows the rate field
    always_comb begin
        unique case (rate)
            RATE_4M: frame_bits = FRAME_BITS_4M;
            RATE_8M: frame_bits = FRAME_BITS_8M;
            default: frame_bits = FRAME_BITS_2M;
        endcase
        last_bit = CM_BIT_W'(frame_bits - FRAME_BITS_DEC);
    end

    // ========================================================
    // memory is not cleared by reset; software reloads it
    always_ff @(posedge clk) begin
        if (wr_en) begin
            cm_mem[word_addr] <= wr_data;
        end
        rd_data <= cm_mem[word_addr];
    end

    // ========================================================
    // bit counter and serial output
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bit_idx_r <= CM_BIT_ZERO;
            bit_out <= 1'b0;
        end else if (frame_start) begin
            bit_idx_r <= CM_BIT_ZERO;
        end else if (bit_en) begin
            bit_idx_r <= (bit_idx_r >= last_bit) ? CM_BIT_ZERO :
                CM_BIT_W'(bit_idx_r + 1'b1);
            bit_out <= cm_mem[bit_idx_r[CM_BIT_W-1:4]][bit_idx_r[3:0]];
        end
    end
endmodule
`default_nettype wire

// [core/scp_host_port.sv]
// host microprocessor port of the time-slot switch with control stream
//
// Notes on behaviour
// - reset clears counters and registers, floats serial and host data outputs
// - frame select high picks wide frame pulse mode, low the standard mode
// - mux select high means multiplexed bus, low non-multiplexed
// - non-multiplexed mode takes the address from the dedicated address lines
// - multiplexed data strobe mode: strobe active high, acts only with chip select
// - non-multiplexed mode: strobe active low, acts only with chip select
// - multiplexed read/write strobes: low read strobe drives the data lines
// - data strobe modes: a single direction line picks read or write and the bus direction
// - multiplexed strobes: low write strobe takes the data lines in
// - chip select low opens the port; otherwise every strobe except the address latch strobe is ignored
// - address latch strobe is used only in multiplexed mode
// - low data byte shares lines with the multiplexed address
// - high data byte has its own lines, giving sixteen data bits
// - acknowledge goes low when the transfer is complete
// - at cycle end acknowledge is driven high, then released
// - control stream has 512, 1024 or 2048 bits per frame by rate
// - each control stream bit comes from the control bit memory
// - two-bit rate field selects serial rate and clock rate; here it only sets the control stream frame length
// - drive enable low and standby bit low float the serial outputs; here the control stream output stays driven outside reset
`timescale 1ns/10ps
`default_nettype none
module scp_host_port (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wide_frame_select,
    input wire logic host_bus_mux_select,
    input wire logic strobe_style_rdwr,
    input wire logic [scp_pkg::ADDR_W-1:0] host_addr_lines,
    input wire logic data_strobe,
    input wire logic dir_write_strobe,
    input wire logic chip_select_n,
    input wire logic addr_latch_strobe,
    input wire logic [scp_pkg::LOW_W-1:0] shared_addr_data_low_i,
    output var logic [scp_pkg::LOW_W-1:0] shared_addr_data_low_o,
    output var logic shared_addr_data_low_oe,
    input wire logic [scp_pkg::LOW_W-1:0] data_high_byte_i,
    output var logic [scp_pkg::LOW_W-1:0] data_high_byte_o,
    output var logic data_high_byte_oe,
    output var logic transfer_ack_n_o,
    output var logic transfer_ack_n_oe,
    input wire logic serial_clk,
    input wire logic frame_pulse_n,
    input wire logic output_drive_enable,
    input wire logic output_standby_bit,
    input wire logic [scp_pkg::RATE_W-1:0] rate_select_field,
    output var logic wide_frame_pulse_mode,
    output var logic serial_out_streams_oe,
    output var logic control_out_stream,
    output var logic control_out_stream_oe
);
    import scp_pkg::*;

    // ========================================================
    // pin synchronisation
    logic [SYNC_W-1:0] pin_async;
    logic [SYNC_W-1:0] pin_s;

    // active-low pins enter inverted so the synchroniser's reset value reads
    // as idle: no phantom access or frame start right after reset
    assign pin_async = {
        data_high_byte_i,
        shared_addr_data_low_i,
        host_addr_lines,
        !chip_select_n,
        data_strobe,
        dir_write_strobe,
        addr_latch_strobe,
        host_bus_mux_select,
        wide_frame_select,
        output_drive_enable,
        serial_clk,
        !frame_pulse_n
    };

    scp_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in(pin_async),
        .sync_out(pin_s)
    );

    logic cs_n_s;
    logic ds_s;
    logic dir_s;
    logic als_s;
    logic mux_s;
    logic wide_frame_select_s;
    logic ode_s;
    logic sclk_s;
    logic fp_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [LOW_W-1:0] adl_s;
    logic [LOW_W-1:0] dh_s;

    assign cs_n_s = !pin_s[SY_CSN];
    assign ds_s = pin_s[SY_DS];
    assign dir_s = pin_s[SY_DIR];
    assign als_s = pin_s[SY_ALS];
    assign mux_s = pin_s[SY_IM];
    assign wide_frame_select_s = pin_s[SY_WIDE_FRAME_SELECT];
    assign ode_s = pin_s[SY_ODE];
    assign sclk_s = pin_s[SY_SCLK];
    assign fp_n_s = !pin_s[SY_FP];
    assign addr_s = pin_s[SY_ADDR +: ADDR_W];
    assign adl_s = pin_s[SY_ADL +: LOW_W];
    assign dh_s = pin_s[SY_DH +: LOW_W];

    // ========================================================
    // edge history of the synchronised pins
    logic als_d_r;
    logic sclk_d_r;
    logic fp_n_d_r;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            als_d_r <= 1'b0;
            sclk_d_r <= 1'b0;
            fp_n_d_r <= 1'b1;
        end else begin
            als_d_r <= als_s;
            sclk_d_r <= sclk_s;
            fp_n_d_r <= fp_n_s;
        end
    end

    // ========================================================
    // strobe decode per bus mode
    logic rd_req;
    logic wr_req;
    logic acc_req;

    always_comb begin
        rd_req = 1'b0;
        wr_req = 1'b0;
        if (!cs_n_s) begin
            if (!mux_s) begin
                rd_req = !ds_s && dir_s;
                wr_req = !ds_s && !dir_s;
            end else if (!strobe_style_rdwr) begin
                rd_req = ds_s && dir_s;
                wr_req = ds_s && !dir_s;
            end else begin
                rd_req = !ds_s && dir_s;
                wr_req = !dir_s && ds_s;
            end
        end
        acc_req = rd_req || wr_req;
    end

    // ========================================================
    // multiplexed address capture on the latch strobe's falling edge
    logic [ADDR_W-1:0] mux_addr_r;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mux_addr_r <= '0;
        end else if (mux_s && als_d_r && !als_s) begin
            mux_addr_r <= adl_s;
        end
    end

    // ========================================================
    // bus cycle sequencer
    scp_bus_st_t st_r;
    logic [3:0] ack_cnt_r;
    logic is_read_r;
    logic [ADDR_W-1:0] acc_addr_r;
    logic cm_wr_en;
    logic [DATA_W-1:0] cm_rd_data;

    // a read can only drive data once the memory word is available, so
    // the acknowledge waits a fixed delay for both directions
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= SCP_IDLE;
            ack_cnt_r <= CNT_ZERO;
            is_read_r <= 1'b0;
            acc_addr_r <= '0;
        end else begin
            unique case (st_r)
                SCP_IDLE: begin
                    if (acc_req) begin
                        st_r <= SCP_WAIT;
                        ack_cnt_r <= ACK_DELAY_CYC;
                        is_read_r <= rd_req;
                        acc_addr_r <= mux_s ? mux_addr_r : addr_s;
                    end
                end
                SCP_WAIT: begin
                    if (!acc_req) begin
                        st_r <= SCP_RELEASE;
                    end else if (ack_cnt_r == CNT_ONE) begin
                        st_r <= SCP_ACKED;
                    end
                    ack_cnt_r <= (ack_cnt_r == CNT_ZERO) ? CNT_ZERO :
                        4'(ack_cnt_r - CNT_ONE);
                end
                SCP_ACKED: begin
                    if (!acc_req) begin
                        st_r <= SCP_RELEASE;
                    end
                end
                SCP_RELEASE: begin
                    st_r <= SCP_IDLE;
                end
            endcase
        end
    end

    // write is committed once, at the moment the acknowledge goes low;
    // an aborted cycle therefore writes nothing
    assign cm_wr_en = (st_r == SCP_WAIT) && (ack_cnt_r == CNT_ONE) && acc_req
        && !is_read_r;

    // ========================================================
    // host data drivers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            shared_addr_data_low_oe <= 1'b0;
            data_high_byte_oe <= 1'b0;
            shared_addr_data_low_o <= '0;
            data_high_byte_o <= '0;
        end else begin
            shared_addr_data_low_oe <= (st_r == SCP_ACKED) && is_read_r && rd_req;
            data_high_byte_oe <= (st_r == SCP_ACKED) && is_read_r && rd_req;
            if (st_r == SCP_WAIT) begin
                shared_addr_data_low_o <= cm_rd_data[LOW_W-1:0];
                data_high_byte_o <= cm_rd_data[DATA_W-1:LOW_W];
            end
        end
    end

    // ========================================================
    // transfer acknowledge: low when done, high for one cycle, then float
    always_ff @(posedge clk) begin
        if (!nrst) begin
            transfer_ack_n_o <= 1'b1;
            transfer_ack_n_oe <= 1'b0;
        end else begin
            unique case (st_r)
                SCP_IDLE: begin
                    transfer_ack_n_o <= 1'b1;
                    transfer_ack_n_oe <= 1'b0;
                end
                SCP_WAIT: begin
                    transfer_ack_n_o <= !(acc_req && ack_cnt_r == CNT_ONE);
                    transfer_ack_n_oe <= 1'b1;
                end
                SCP_ACKED: begin
                    transfer_ack_n_o <= !acc_req;
                    transfer_ack_n_oe <= 1'b1;
                end
                SCP_RELEASE: begin
                    transfer_ack_n_o <= 1'b1;
                    transfer_ack_n_oe <= 1'b0;
                end
            endcase
        end
    end

    // ========================================================
    // control bit memory and control stream
    logic bit_en;
    logic frame_start;
    logic ctl_bit;
    logic [DATA_W-1:0] wr_word;

    assign bit_en = sclk_s && !sclk_d_r;
    assign frame_start = fp_n_d_r && !fp_n_s;
    assign wr_word = {dh_s, adl_s};

    scp_ctl_stream u_ctl (
        .clk(clk),
        .nrst(nrst),
        .rate(rate_select_field),
        .bit_en(bit_en),
        .frame_start(frame_start),
        .wr_en(cm_wr_en),
        .word_addr(acc_addr_r[CM_AW-1:0]),
        .wr_data(wr_word),
        .rd_data(cm_rd_data),
        .bit_out(ctl_bit)
    );

    // ========================================================
    // mode and serial output enables
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wide_frame_pulse_mode <= 1'b0;
            serial_out_streams_oe <= 1'b0;
            control_out_stream <= 1'b0;
            control_out_stream_oe <= 1'b0;
        end else begin
            wide_frame_pulse_mode <= wide_frame_select_s;
            serial_out_streams_oe <= ode_s || output_standby_bit;
            control_out_stream <= ctl_bit;
            control_out_stream_oe <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// [core/scp_sync.sv]
// two flip-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module scp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] async_in,
    output var logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // each bit is independent; multi-bit groups are only sampled when
    // their strobe says they are stable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// [dv/scp_host_model.sv]
// host microprocessor model driving the port's bus pins
`timescale 1ns/10ps
`default_nettype none
module scp_host_model (
    input wire logic clk,
    input wire logic ack_n,
    input wire logic [7:0] ad_in,
    input wire logic [7:0] dh_in,
    output var logic mux,
    output var logic rdwr,
    output var logic [7:0] addr,
    output var logic ds,
    output var logic dir,
    output var logic cs_n,
    output var logic ale,
    output var logic [7:0] ad_out,
    output var logic [7:0] dh_out,
    output var logic drv
);
    initial begin
        mux = 1'b0;
        rdwr = 1'b0;
        addr = 8'h00;
        ds = 1'b1;
        dir = 1'b1;
        cs_n = 1'b1;
        ale = 1'b0;
        ad_out = 8'h00;
        dh_out = 8'h00;
        drv = 1'b0;
    end

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // ========================================================
    // one bus cycle; m 0 non-mux, 1 mux data strobe, 2 mux read/write strobes
    task automatic access(input logic [1:0] m, input logic rd, input logic sel,
            input logic [7:0] a, input logic [15:0] wd, output logic [15:0] q, output logic ok);
        int n;
        step(1);
        mux = (m != 2'h0);
        rdwr = (m == 2'h2);
        ds = (m != 2'h1);
        dir = (m == 2'h2) || rd;
        // mux mode must ignore these lines
        addr = mux ? ~a : a;
        ad_out = a;
        drv = mux;
        ale = mux;
        step(4);
        ale = 1'b0;
        step(3);
        {dh_out, ad_out} = wd;
        drv = !rd;
        cs_n = !sel;
        if (m == 2'h2) begin
            ds = !rd;
            dir = rd;
        end else begin
            ds = mux;
        end
        for (n = 0; n < 40 && ack_n !== 1'b0; n++) begin
            step(1);
        end
        ok = (ack_n === 1'b0);
        step(1);
        q = {dh_in, ad_in};
        ds = (m != 2'h1);
        dir = 1'b1;
        cs_n = 1'b1;
        drv = 1'b0;
        step(8);
    endtask
endmodule
`default_nettype wire

// [dv/scp_host_port_chk.sv]
// concurrent checks on the host port pins
`timescale 1ns/10ps
`default_nettype none
module scp_host_port_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wide_frame_select,
    input wire logic chip_select_n,
    input wire logic shared_addr_data_low_oe,
    input wire logic data_high_byte_oe,
    input wire logic transfer_ack_n_o,
    input wire logic transfer_ack_n_oe,
    input wire logic serial_clk,
    input wire logic output_drive_enable,
    input wire logic output_standby_bit,
    input wire logic wide_frame_pulse_mode,
    input wire logic serial_out_streams_oe,
    input wire logic control_out_stream
);
    // ========================================================
    // pins pass a two flop synchroniser, hence the four cycle runs
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    chk_reset_floats: assert property (disable iff (1'b0)
        !nrst |=> !shared_addr_data_low_oe && !transfer_ack_n_oe && !serial_out_streams_oe)
        else $error("outputs driven in reset");
    chk_ack_latency: assert property ($fell(transfer_ack_n_o) |-> $past(transfer_ack_n_oe, 3))
        else $error("ack low too early");
    chk_ack_release: assert property (
        $rose(transfer_ack_n_o) && transfer_ack_n_oe |=> !transfer_ack_n_oe)
        else $error("ack not released after high");
    chk_ack_high_first: assert property ($fell(transfer_ack_n_oe) |-> $past(transfer_ack_n_o))
        else $error("ack released while low");
    chk_data_with_ack: assert property (shared_addr_data_low_oe |-> transfer_ack_n_oe)
        else $error("data driven outside a cycle");
    chk_bytes_together: assert property (shared_addr_data_low_oe == data_high_byte_oe)
        else $error("data bytes driven apart");
    chk_cs_gate: assert property (chip_select_n [*8] |->
        (transfer_ack_n_o || !transfer_ack_n_oe) && !shared_addr_data_low_oe)
        else $error("activity while deselected");
    chk_serial_float: assert property (
        (!output_drive_enable && !output_standby_bit) [*4] |=> !serial_out_streams_oe)
        else $error("serial outputs not floated");
    chk_serial_drive: assert property (output_drive_enable [*4] |=> serial_out_streams_oe)
        else $error("serial outputs not driven");
    chk_wide_mode: assert property (wide_frame_select [*4] |=> wide_frame_pulse_mode)
        else $error("wide frame mode not set");
    chk_std_mode: assert property (!wide_frame_select [*4] |=> !wide_frame_pulse_mode)
        else $error("standard frame mode not set");
    chk_bit_steady: assert property ((!serial_clk) [*8] |-> $stable(control_out_stream))
        else $error("control bit moved without clock");
endmodule
bind scp_host_port scp_host_port_chk i_chk (.clk, .nrst, .wide_frame_select, .chip_select_n,
    .shared_addr_data_low_oe, .data_high_byte_oe, .transfer_ack_n_o, .transfer_ack_n_oe,
    .serial_clk, .output_drive_enable, .output_standby_bit, .wide_frame_pulse_mode,
    .serial_out_streams_oe, .control_out_stream);
`default_nettype wire

// [dv/scp_host_port_tb.sv]
// self-checking bench for the switch cpu host port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, s) begin n_tests++; if ((a) !== (e)) begin errors++; \
    $display("mismatch at %0t: %s", $time, s); end end
module scp_host_port_tb;
    import scp_pkg::*;
    logic clk = 1'b0;
    logic nrst, wide_frame_select, serial_clk, frame_pulse_n;
    logic output_drive_enable, output_standby_bit;
    logic [1:0] rate_select_field;
    logic host_bus_mux_select, strobe_style_rdwr, data_strobe, dir_write_strobe, chip_select_n;
    logic addr_latch_strobe, drv, shared_addr_data_low_oe, data_high_byte_oe, b, ok;
    logic transfer_ack_n_o, transfer_ack_n_oe, wide_frame_pulse_mode, serial_out_streams_oe;
    logic control_out_stream, control_out_stream_oe;
    logic [7:0] host_addr_lines, ad_out, dh_out, shared_addr_data_low_o, data_high_byte_o;
    logic [7:0] pat = 8'h5a;
    logic [15:0] q;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [6:0] wa [6] = '{7'h00, 7'h01, 7'h1f, 7'h20, 7'h3f, 7'h7f};
    logic [15:0] wd [6] = '{16'hc35b, 16'h5a3c, 16'h8000, 16'h0000, 16'h8000, 16'h8000};
    // pull-up holds the acknowledge high once released
    wire logic ack_w = transfer_ack_n_oe ? transfer_ack_n_o : 1'b1;
    // released data lines wander so stale values cannot pass
    wire logic [7:0] shared_addr_data_low_i = shared_addr_data_low_oe ? shared_addr_data_low_o
        : drv ? ad_out : pat;
    wire logic [7:0] data_high_byte_i = data_high_byte_oe ? data_high_byte_o : drv ? dh_out : ~pat;

    scp_host_port i_dut (.clk, .nrst, .wide_frame_select, .host_bus_mux_select,
        .strobe_style_rdwr, .host_addr_lines, .data_strobe, .dir_write_strobe, .chip_select_n,
        .addr_latch_strobe, .shared_addr_data_low_i, .shared_addr_data_low_o,
        .shared_addr_data_low_oe, .data_high_byte_i, .data_high_byte_o, .data_high_byte_oe,
        .transfer_ack_n_o, .transfer_ack_n_oe, .serial_clk, .frame_pulse_n,
        .output_drive_enable, .output_standby_bit, .rate_select_field, .wide_frame_pulse_mode,
        .serial_out_streams_oe, .control_out_stream, .control_out_stream_oe);
    scp_host_model i_host (.clk, .ack_n(ack_w), .ad_in(shared_addr_data_low_i),
        .dh_in(data_high_byte_i), .mux(host_bus_mux_select), .rdwr(strobe_style_rdwr),
        .addr(host_addr_lines), .ds(data_strobe), .dir(dir_write_strobe), .cs_n(chip_select_n),
        .ale(addr_latch_strobe), .ad_out, .dh_out, .drv);

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        pat <= pat + 8'h3b;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic ctl_bit(output logic v);
        serial_clk = 1'b1;
        i_host.step(4);
        serial_clk = 1'b0;
        i_host.step(4);
        v = control_out_stream;
    endtask

    task automatic frame_start();
        frame_pulse_n = 1'b0;
        i_host.step(6);
        frame_pulse_n = 1'b1;
        i_host.step(6);
    endtask

    // ========================================================
    // test sequence
    initial begin
        int i;
        int r;
        int n;
        nrst = 1'b0;
        wide_frame_select = 1'b0;
        serial_clk = 1'b0;
        frame_pulse_n = 1'b1;
        {output_drive_enable, output_standby_bit} = 2'h0;
        rate_select_field = 2'h0;
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        i_host.step(4);
        // each word written in one bus style, read back in the next
        for (i = 0; i < 6; i++) begin
            i_host.access(2'(i % 3), 1'b0, 1'b1, {1'b0, wa[i]}, wd[i], q, ok);
            `CHK(ok, 1'b1, "write not acknowledged")
        end
        for (i = 0; i < 6; i++) begin
            i_host.access(2'((i + 1) % 3), 1'b1, 1'b1, {1'b0, wa[i]}, 16'h0000, q, ok);
            `CHK(q, wd[i], "read data")
        end
        i_host.access(2'h0, 1'b0, 1'b0, 8'h01, 16'hffff, q, ok);
        `CHK(ok, 1'b0, "deselected write acknowledged")
        i_host.access(2'h1, 1'b1, 1'b1, 8'h01, 16'h0000, q, ok);
        `CHK(q, 16'h5a3c, "deselected write landed")
        $display("test host bus done");
        for (i = 0; i < 4; i++) begin
            {output_drive_enable, output_standby_bit} = 2'(i);
            wide_frame_select = i[0];
            i_host.step(6);
            `CHK(serial_out_streams_oe, i != 0, "serial enable")
            `CHK(wide_frame_pulse_mode, i[0], "frame mode")
        end
        nrst = 1'b0;
        i_host.step(RST_MIN_CYC);
        `CHK({serial_out_streams_oe, shared_addr_data_low_oe, control_out_stream_oe, ack_w}, 4'h1, "reset state")
        nrst = 1'b1;
        i_host.step(4);
        `CHK(control_out_stream_oe, 1'b1, "control stream enable")
        $display("test modes and reset done");
        rate_select_field = RATE_8M;
        frame_start();
        for (i = 0; i < 32; i++) begin
            ctl_bit(b);
            `CHK(b, wd[i / 16][i % 16], "control bit")
        end
        for (r = 0; r < 4; r++) begin
            rate_select_field = 2'(r);
            n = (r == 1) ? 1024 : (r == 2) ? 2048 : 512;
            frame_start();
            for (i = 1; i <= n + 1; i++) begin
                ctl_bit(b);
                if (i >= n) `CHK(b, 1'b1, "frame end or wrap")
                if (i == 513) `CHK(b, n == 512, "bit after 512")
            end
        end
        $display("test control stream done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// [pkg/scp_pkg.sv]
// shared constants and types for the switch cpu host port
package scp_pkg;

    // ========================================================
    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int LOW_W = 8;
    localparam int RATE_W = 2;

    // ========================================================
    // pin synchroniser layout (low index first)
    localparam int SY_FP = 0;
    localparam int SY_SCLK = 1;
    localparam int SY_ODE = 2;
    localparam int SY_WIDE_FRAME_SELECT = 3;
    localparam int SY_IM = 4;
    localparam int SY_ALS = 5;
    localparam int SY_DIR = 6;
    localparam int SY_DS = 7;
    localparam int SY_CSN = 8;
    localparam int SY_ADDR = 9;
    localparam int SY_ADL = 17;
    localparam int SY_DH = 25;
    localparam int SYNC_W = 33;

    // ========================================================
    // serial rate field codes and bits per frame on the control stream
    localparam logic [1:0] RATE_2M = 2'h0;
    localparam logic [1:0] RATE_4M = 2'h1;
    localparam logic [1:0] RATE_8M = 2'h2;
    localparam logic [11:0] FRAME_BITS_2M = 12'h200;
    localparam logic [11:0] FRAME_BITS_4M = 12'h400;
    localparam logic [11:0] FRAME_BITS_8M = 12'h800;
    localparam logic [11:0] FRAME_BITS_DEC = 12'h001;

    // ========================================================
    // control bit memory: 2048 bits as 128 words of 16
    localparam int CM_AW = 7;
    localparam int CM_WORDS = 128;
    localparam int CM_BIT_W = 11;
    localparam logic [CM_BIT_W-1:0] CM_BIT_ZERO = 11'h000;

    // ========================================================
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int RST_MIN_NS = 100;
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_DELAY_NS = 20;
    localparam int ACK_DELAY_CYC_I = (ACK_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
        ACK_DELAY_NS / CLK_PERIOD_NS;
    localparam logic [3:0] ACK_DELAY_CYC = 4'(ACK_DELAY_CYC_I);
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;

    // ========================================================
    // host bus cycle states
    typedef enum logic [1:0] {
        SCP_IDLE,
        SCP_WAIT,
        SCP_ACKED,
        SCP_RELEASE
    } scp_bus_st_t;

endpackage
